// ---- design/mbecc_div.v ----
// Byte-serial polynomial divider: shifts one byte in per enable, MSB first,
// and keeps the remainder modulo a polynomial of programmable degree.
module mbecc_div #(
   parameter W = 14
) (
   input wire clk, // System clock.
   input wire srst, // Synchronous reset, active high.
   input wire en, // A byte is present this cycle.
   input wire last, // This byte ends the sector; state restarts after it.
   input wire restart, // Clear the state without taking a byte.
   input wire [7:0] din, // Incoming byte.
   input wire [W-1:0] poly, // Polynomial terms below the leading one.
   input wire [8:0] deg, // Polynomial degree, at most W.
   output wire [W-1:0] nxt_rem // Remainder including the byte this cycle.
);

   reg [W-1:0] rem_ff;
   reg [W-1:0] nxt_calc;
   reg [W-1:0] mask;
   reg fb;
   integer b;
   integer k;

   // Eight shift steps per byte; bits above the degree are masked away.
   always @* begin
      nxt_calc = rem_ff;
      mask = {W{1'b0}};
      fb = 1'b0;
      for (k = 0; k < W; k = k + 1) begin
         mask[k] = (k < deg);
      end
      for (b = 7; b >= 0; b = b - 1) begin
         fb = nxt_calc[deg-1] ^ din[b];
         nxt_calc = {nxt_calc[W-2:0], 1'b0} & mask;
         if (fb) begin
            nxt_calc = nxt_calc ^ (poly & mask);
         end
      end
   end

   assign nxt_rem = en ? nxt_calc : rem_ff;

   // Sector boundary wipes the state so sectors stay independent.
   always @(posedge clk) begin
      if (srst || restart) begin
         rem_ff <= {W{1'b0}};
      end else if (en && last) begin
         rem_ff <= {W{1'b0}};
      end else if (en) begin
         rem_ff <= nxt_calc;
      end
   end

endmodule

// ---- design/mbecc_engine.v ----
`include "mbecc_regs.vh"

module mbecc_engine #(
   parameter SPW = 9,
   parameter [10*`MBECC_RED_W-1:0] GEN_POLY = {10{336'h1B}},
   parameter [`MBECC_REM_N*`MBECC_REM_W-1:0] MIN_POLY13 = {48{14'h001B}},
   parameter [`MBECC_REM_N*`MBECC_REM_W-1:0] MIN_POLY14 = {48{14'h0443}}
) (
   input wire clk, // System clock, 100 MHz.
   input wire srst, // Synchronous reset, active high.
   input wire cfg_write_direction_select, // 1 encodes, 0 checks.
   input wire cfg_spare_protect_enable, // Spare area is protected.
   input wire [2:0] cfg_correction_capability_field, // Capability code.
   input wire cfg_sector_1024, // 1 selects 1024-byte sectors.
   input wire [1:0] cfg_sectors_per_page, // 0..3 for 1, 2, 4, 8.
   input wire [SPW-1:0] cfg_spare_size, // Spare bytes in the page.
   input wire [SPW-1:0] cfg_ecc_start, // First skipped spare offset.
   input wire [SPW-1:0] cfg_ecc_end, // Last skipped spare offset.
   input wire page_start, // Pulse: start a page, latch the setup.
   input wire nand_valid, // A NAND data byte is present.
   input wire [7:0] nand_data, // NAND data byte.
   input wire [2:0] sector_sel, // Sector whose results are shown.
   input wire status_clear, // Pulse: clear the sector error status.
   output reg busy_ff, // Page in progress.
   output reg page_done_ff, // Pulse: last byte of the page taken.
   output reg [7:0] sector_error_status_ff, // One bit per bad sector.
   output reg irq_ff, // Interrupt, high while any status bit set.
   output reg [5:0] ecc_bytes_ff, // ECC bytes per sector for the setup.
   output reg [`MBECC_RED_W-1:0] redundancy_ff, // Selected redundancy.
   output reg [`MBECC_REM_N*`MBECC_REM_W-1:0] remainder_ff // Remainders.
);

   localparam RW = `MBECC_RED_W;
   localparam MW = `MBECC_REM_W;
   localparam NR = `MBECC_REM_N;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg dir_ff;
   reg spare_ff;
   reg [2:0] cap_ff;
   reg big_ff;
   reg [1:0] spp_ff;
   reg [SPW-1:0] spare_size_ff;
   reg [SPW-1:0] ecc_start_ff;
   reg [SPW-1:0] ecc_end_ff;
   reg [11:0] cnt_ff;
   reg [2:0] sec_ff;
   reg [RW-1:0] red_mem [0:`MBECC_SECTORS-1];
   reg [NR*MW-1:0] rem_mem [0:`MBECC_SECTORS-1];

   reg [8:0] t_val;
   reg [8:0] m_val;
   reg [5:0] eb_val;
   reg [10:0] sec_len;
   reg [11:0] seg_len;
   reg last_sec;
   reg in_spare;
   reg [SPW-1:0] spare_off;
   reg skip;
   reg [2:0] cap_eff;
   reg [3:0] gidx;
   reg [NR*MW-1:0] rem_masked;
   reg rem_nz;
   integer i;

   wire run = (state_ff == `MBECC_ST_RUN);
   wire take = run && nand_valid;
   wire seg_end = take && (cnt_ff == seg_len - 12'h001);
   wire page_end = seg_end && last_sec;
   wire [RW-1:0] nxt_red;
   wire [NR*MW-1:0] nxt_rems;

   // Capability and field size decode; codes above the top one act as 0.
   always @* begin
      cap_eff = (cap_ff > `MBECC_CAP_24) ? `MBECC_CAP_2 : cap_ff;
      m_val = big_ff ? `MBECC_M_1024 : `MBECC_M_512;
      sec_len = big_ff ? `MBECC_SEC_1024 : `MBECC_SEC_512;
      case (cap_eff)
         `MBECC_CAP_2: t_val = `MBECC_T_2;
         `MBECC_CAP_4: t_val = `MBECC_T_4;
         `MBECC_CAP_8: t_val = `MBECC_T_8;
         `MBECC_CAP_12: t_val = `MBECC_T_12;
         default: t_val = `MBECC_T_24;
      endcase
      case (cap_eff)
         `MBECC_CAP_2: eb_val = `MBECC_EB_CAP0;
         `MBECC_CAP_4: eb_val = `MBECC_EB_CAP1;
         `MBECC_CAP_8: eb_val = big_ff ? `MBECC_EB_CAP2_1024 :
                                         `MBECC_EB_CAP2_512;
         `MBECC_CAP_12: eb_val = big_ff ? `MBECC_EB_CAP3_1024 :
                                          `MBECC_EB_CAP3_512;
         default: eb_val = big_ff ? `MBECC_EB_CAP4_1024 :
                                    `MBECC_EB_CAP4_512;
      endcase
      gidx = {cap_eff, big_ff};
   end

   // Segment length: sector data plus spare on the last sector when
   // protected, or plus the inline ECC bytes on an unprotected read.
   always @* begin
      last_sec = (sec_ff == ((3'h1 << spp_ff) - 3'h1));
      seg_len = {1'b0, sec_len};
      if (spare_ff && last_sec) begin
         seg_len = {1'b0, sec_len} + {{(12-SPW){1'b0}}, spare_size_ff};
      end else if (!spare_ff && !dir_ff) begin
         seg_len = {1'b0, sec_len} + {6'h00, eb_val};
      end
      in_spare = spare_ff && last_sec && (cnt_ff >= {1'b0, sec_len});
      spare_off = cnt_ff[SPW-1:0] - sec_len[SPW-1:0];
      skip = !dir_ff && in_spare && (spare_off >= ecc_start_ff) &&
             (spare_off <= ecc_end_ff);
   end

   // Encoder: remainder modulo the generator of degree m times t.
   mbecc_div #(
      .W(RW)
   ) u_enc (
      .clk(clk),
      .srst(srst),
      .en(take && dir_ff),
      .last(seg_end),
      .restart(page_start),
      .din(nand_data),
      .poly(GEN_POLY[gidx*RW +: RW]),
      .deg(t_val * m_val),
      .nxt_rem(nxt_red)
   );

   // One remainder divider per minimal polynomial of the code.
   genvar g;
   generate
      for (g = 0; g < NR; g = g + 1) begin : g_rem
         mbecc_div #(
            .W(MW)
         ) u_rem (
            .clk(clk),
            .srst(srst),
            .en(take && !dir_ff && !skip),
            .last(seg_end),
            .restart(page_start),
            .din(nand_data),
            .poly(big_ff ? MIN_POLY14[g*MW +: MW] : MIN_POLY13[g*MW +: MW]),
            .deg(m_val),
            .nxt_rem(nxt_rems[g*MW +: MW])
         );
      end
   endgenerate

   // Only the first 2t remainders belong to the selected capability.
   always @* begin
      rem_masked = nxt_rems;
      rem_nz = 1'b0;
      for (i = 0; i < NR; i = i + 1) begin
         if (i >= {t_val, 1'b0}) begin
            rem_masked[i*MW +: MW] = {MW{1'b0}};
         end
         if (rem_masked[i*MW +: MW] != {MW{1'b0}}) begin
            rem_nz = 1'b1;
         end
      end
   end

   // Page sequencer.
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `MBECC_ST_IDLE: begin
            if (page_start) begin
               nxt_state = `MBECC_ST_RUN;
            end
         end
         `MBECC_ST_RUN: begin
            if (page_end) begin
               nxt_state = `MBECC_ST_DONE;
            end
         end
         default: begin
            nxt_state = `MBECC_ST_IDLE;
         end
      endcase
      if (page_start) begin
         nxt_state = `MBECC_ST_RUN;
      end
   end

   // Setup is latched at page start so a mid-page change cannot split
   // a sector between two configurations.
   always @(posedge clk) begin
      if (srst) begin
         state_ff <= `MBECC_ST_IDLE;
         dir_ff <= 1'b0;
         spare_ff <= 1'b0;
         cap_ff <= `MBECC_CAP_2;
         big_ff <= 1'b0;
         spp_ff <= 2'h0;
         spare_size_ff <= {SPW{1'b0}};
         ecc_start_ff <= {SPW{1'b0}};
         ecc_end_ff <= {SPW{1'b0}};
      end else begin
         state_ff <= nxt_state;
         if (page_start) begin
            dir_ff <= cfg_write_direction_select;
            spare_ff <= cfg_spare_protect_enable;
            cap_ff <= cfg_correction_capability_field;
            big_ff <= cfg_sector_1024;
            spp_ff <= cfg_sectors_per_page;
            spare_size_ff <= cfg_spare_size;
            ecc_start_ff <= cfg_ecc_start;
            ecc_end_ff <= cfg_ecc_end;
         end
      end
   end

   // Byte and sector counters.
   always @(posedge clk) begin
      if (srst || page_start) begin
         cnt_ff <= 12'h000;
         sec_ff <= 3'h0;
      end else if (seg_end) begin
         cnt_ff <= 12'h000;
         sec_ff <= last_sec ? 3'h0 : sec_ff + 3'h1;
      end else if (take) begin
         cnt_ff <= cnt_ff + 12'h001;
      end
   end

   // Results are written only when their own sector ends, so earlier
   // sectors stay readable while later ones are still streaming.
   always @(posedge clk) begin
      if (seg_end && dir_ff) begin
         red_mem[sec_ff] <= nxt_red;
      end
      if (seg_end && !dir_ff) begin
         rem_mem[sec_ff] <= rem_masked;
      end
   end

   // Status bits: a new corruption wins over a clear in the same cycle.
   always @(posedge clk) begin
      if (srst) begin
         sector_error_status_ff <= 8'h00;
         irq_ff <= 1'b0;
      end else begin
         sector_error_status_ff <= nxt_status(sector_error_status_ff);
         irq_ff <= |nxt_status(sector_error_status_ff);
      end
   end

   function [7:0] nxt_status;
      input [7:0] cur;
      begin
         nxt_status = status_clear ? 8'h00 : cur;
         if (seg_end && !dir_ff && rem_nz) begin
            nxt_status[sec_ff] = 1'b1;
         end
      end
   endfunction

   // Registered views of the selected sector and of the setup.
   always @(posedge clk) begin
      if (srst) begin
         busy_ff <= 1'b0;
         page_done_ff <= 1'b0;
         ecc_bytes_ff <= 6'h00;
         redundancy_ff <= {RW{1'b0}};
         remainder_ff <= {(NR*MW){1'b0}};
      end else begin
         busy_ff <= (nxt_state == `MBECC_ST_RUN);
         page_done_ff <= page_end && !page_start;
         ecc_bytes_ff <= eb_val;
         redundancy_ff <= red_mem[sector_sel];
         remainder_ff <= rem_mem[sector_sel];
      end
   end

endmodule

// ---- design/mbecc_regs.vh ----
`ifndef MBECC_REGS_VH
`define MBECC_REGS_VH

// Correction capability codes, one per supported error count.
`define MBECC_CAP_2 3'h0
`define MBECC_CAP_4 3'h1
`define MBECC_CAP_8 3'h2
`define MBECC_CAP_12 3'h3
`define MBECC_CAP_24 3'h4

// Errors corrected for each capability code.
`define MBECC_T_2 9'h002
`define MBECC_T_4 9'h004
`define MBECC_T_8 9'h008
`define MBECC_T_12 9'h00C
`define MBECC_T_24 9'h018

// Field degree for each sector size.
`define MBECC_M_512 9'h00D
`define MBECC_M_1024 9'h00E

// Sector lengths in bytes.
`define MBECC_SEC_512 11'h200
`define MBECC_SEC_1024 11'h400

// Meaningful ECC bytes per sector, 512-byte and 1024-byte figures.
`define MBECC_EB_CAP0 6'h04
`define MBECC_EB_CAP1 6'h07
`define MBECC_EB_CAP2_512 6'h0D
`define MBECC_EB_CAP2_1024 6'h0E
`define MBECC_EB_CAP3_512 6'h14
`define MBECC_EB_CAP3_1024 6'h15
`define MBECC_EB_CAP4_512 6'h27
`define MBECC_EB_CAP4_1024 6'h2A

// Largest redundancy and remainder sizes.
`define MBECC_RED_W 336
`define MBECC_REM_W 14
`define MBECC_REM_N 48
`define MBECC_SECTORS 8

// Page sequencer state codes.
`define MBECC_ST_IDLE 2'h0
`define MBECC_ST_RUN 2'h1
`define MBECC_ST_DONE 2'h2

`endif

// ---- testbench/mbecc_engine_properties.sv ----
`include "mbecc_regs.vh"

// Port checks; redundancy is watched only after a page ended, since the
// result arrays power up unknown.
module mbecc_engine_props (
   input wire logic clk, // Clock.
   input wire logic srst, // Reset.
   input wire logic page_start, // Page start.
   input wire logic nand_valid, // Byte present.
   input wire logic [2:0] sector_sel, // Result select.
   input wire logic status_clear, // Status clear.
   input wire logic busy_ff, // Busy.
   input wire logic page_done_ff, // Page end.
   input wire logic [7:0] sector_error_status_ff, // Bad sectors.
   input wire logic irq_ff, // Interrupt.
   input wire logic [5:0] ecc_bytes_ff, // ECC bytes.
   input wire logic [`MBECC_RED_W-1:0] redundancy_ff // Redundancy.
);
   logic seen_ff;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // Set once the first page has ended.
   always @(posedge clk) begin
      if (srst)
         seen_ff <= 1'b0;
      else if (page_done_ff)
         seen_ff <= 1'b1;
   end
   busy_start_a: assert property (page_start |=> busy_ff)
      else $error("busy missing after page start");
   busy_hold_a: assert property (
      busy_ff && !nand_valid && !page_start |=> busy_ff)
      else $error("page ended without a byte");
   done_fall_a: assert property (page_done_ff == $fell(busy_ff))
      else $error("page end pulse misplaced");
   done_byte_a: assert property (page_done_ff |-> $past(nand_valid))
      else $error("page end without a last byte");
   irq_level_a: assert property (irq_ff == |sector_error_status_ff)
      else $error("interrupt differs from status");
   stat_clear_a: assert property (
      status_clear && !busy_ff && !page_done_ff
      |=> sector_error_status_ff == 8'h00)
      else $error("status not cleared");
   stat_keep_a: assert property (
      !status_clear && !busy_ff && !page_done_ff
      |=> $stable(sector_error_status_ff))
      else $error("status changed while idle");
   ecc_table_a: assert property (
      !busy_ff && !$past(srst) && !$past(srst, 2) |-> ecc_bytes_ff inside
      {6'h04, 6'h07, 6'h0D, 6'h0E, 6'h14, 6'h15, 6'h27, 6'h2A})
      else $error("ECC byte count outside table");
   red_keep_a: assert property (
      (seen_ff && !busy_ff && $stable(sector_sel)) [*3]
      |=> $stable(redundancy_ff))
      else $error("redundancy changed while idle");
   cover property (page_done_ff);
   cover property (irq_ff && status_clear);
   cover property (busy_ff && !nand_valid);
endmodule

bind mbecc_engine mbecc_engine_props u_props (.clk(clk), .srst(srst),
   .page_start(page_start), .nand_valid(nand_valid),
   .sector_sel(sector_sel), .status_clear(status_clear),
   .busy_ff(busy_ff), .page_done_ff(page_done_ff),
   .sector_error_status_ff(sector_error_status_ff), .irq_ff(irq_ff),
   .ecc_bytes_ff(ecc_bytes_ff), .redundancy_ff(redundancy_ff));

// ---- testbench/mbecc_engine_tb.sv ----
`include "mbecc_regs.vh"

// Streams pages through the engine and checks counts, results and status.
module mbecc_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, dir = 1'b1, spe = 1'b0, big = 1'b0;
   logic ps = 1'b0, go = 1'b0, gap = 1'b0, sclr = 1'b0;
   logic [2:0] cap = 3'h0, sel = 3'h0;
   logic [1:0] spp = 2'h0;
   logic [8:0] ssz = 9'h000, es = 9'h000, ee = 9'h000;
   logic [13:0] len = 14'h0001, epos = 14'h0000;
   logic [7:0] eval = 8'h00;
   logic nv, pd, busy, irq, done;
   logic [7:0] nd, st;
   logic [5:0] eb;
   logic [`MBECC_RED_W-1:0] red;
   logic [`MBECC_REM_N*`MBECC_REM_W-1:0] rem;
   logic [11:0] rows [11];
   int num_errors = 0, check_count = 0;
   int tt [5] = '{2, 4, 8, 12, 24};
   always #5 clk = ~clk;
   mbecc_engine u_dut (.clk(clk), .srst(srst),
      .cfg_write_direction_select(dir), .cfg_spare_protect_enable(spe),
      .cfg_correction_capability_field(cap), .cfg_sector_1024(big),
      .cfg_sectors_per_page(spp), .cfg_spare_size(ssz),
      .cfg_ecc_start(es), .cfg_ecc_end(ee), .page_start(ps),
      .nand_valid(nv), .nand_data(nd), .sector_sel(sel),
      .status_clear(sclr), .busy_ff(busy), .page_done_ff(pd),
      .sector_error_status_ff(st), .irq_ff(irq), .ecc_bytes_ff(eb),
      .redundancy_ff(red), .remainder_ff(rem));
   mbecc_nand_src u_src (.clk(clk), .go(go), .gap(gap), .len(len),
      .epos(epos), .eval(eval), .nand_valid(nv), .nand_data(nd),
      .done(done));
   task automatic chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Meaningful low bits of the shown redundancy, moved to the top.
   function automatic logic [`MBECC_RED_W-1:0] lowred(input int mt);
      return red << (`MBECC_RED_W - mt);
   endfunction
   // One page of n bytes, byte p set to v; waits until results land.
   task automatic page(input logic [13:0] n, p, input logic [7:0] v);
      int k;
      {len, epos, eval, ps, go} = {n, p, v, 2'b11};
      tick(1);
      {ps, go} = 2'b00;
      k = 0;
      while (done !== 1'b1 && k < 20000) begin
         chk(busy === 1'b1, "busy dropped early");
         tick(1);
         k++;
      end
      chk(pd === 1'b1 && busy === 1'b0, "page end");
      tick(2);
   endtask
   task automatic print_verdict;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Rows: capability code, 1024-byte flag, sectors code, ECC bytes.
   initial begin
      rows = '{12'h0C4, 12'h207, 12'h40D, 12'h614, 12'h867, 12'h104,
         12'h307, 12'h54E, 12'h715, 12'h9EA, 12'hA04};
      tick(4);
      chk(busy === 1'b0 && pd === 1'b0 && st === 8'h00, "reset");
      srst = 1'b0;
      tick(2);
      chk(eb === 6'h04, "ECC bytes after reset");
      dir = 1'b1;
      foreach (rows[i]) begin
         {cap, big, spp} = rows[i][11:6];
         page(14'h0200 << ({1'b0, spp} + big), 14'h3FFF, 8'h00);
         chk(eb === rows[i][5:0], "ECC byte count");
         chk(lowred((13 + big) * tt[cap > 3'h4 ? 0 : cap]) === '0,
            "clean redundancy");
      end
      // Spare rides on the last sector; a flipped first byte must not
      // leak into the next sector.
      {cap, big, spp, spe, ssz} = {3'h1, 1'b0, 2'h1, 1'b1, 9'h010};
      page(14'h0410, 14'h0000, 8'h80);
      chk(|lowred(52) === 1'b1, "sector 0 redundancy");
      sel = 3'h1;
      tick(2);
      chk(lowred(52) === '0, "sector 1 redundancy");
      {dir, spe, spp, cap, gap} = {1'b0, 1'b0, 2'h2, 3'h0, 1'b1};
      page(14'h0810, 14'h040D, 8'h01);
      chk(st === 8'h04 && irq === 1'b1, "corrupted sector");
      sel = 3'h2;
      tick(2);
      for (int i = 0; i < 4; i++)
         chk(|rem[14*i +: 14] === 1'b1, "remainder");
      chk((rem >> 56) === '0, "unused remainders");
      sel = 3'h1;
      tick(2);
      chk(rem === '0, "clean sector remainders");
      sclr = 1'b1;
      tick(1);
      chk(st === 8'h00 && irq === 1'b0, "status clear");
      sclr = 1'b0;
      {spe, spp, gap} = {1'b1, 2'h1, 1'b0};
      {ssz, es, ee} = {9'h020, 9'h004, 9'h00B};
      page(14'h0420, 14'h0404, 8'h01);
      chk(st === 8'h00, "skipped spare byte");
      page(14'h0420, 14'h040C, 8'h01);
      chk(st === 8'h02, "protected spare byte");
      // Reset in mid-page: busy, page end, interrupt, status and ECC bytes drop and the rest of the old
      // stream is ignored until the next page start.
      {spe, spp} = {1'b0, 2'h0};
      {len, epos, eval, ps, go} = {14'h0040, 14'h3FFF, 8'h00, 2'b11};
      tick(1);
      {ps, go} = 2'b00;
      tick(8);
      srst = 1'b1;
      tick(2);
      chk({busy, pd, irq, st, eb} === 17'h00000, "mid-page reset");
      srst = 1'b0;
      tick(2);
      chk(eb === 6'h04, "ECC bytes after second reset");
      tick(60);
      chk(busy === 1'b0 && pd === 1'b0, "stale stream ignored");
      // A page start in mid-page throws away the bytes taken so far.
      {len, epos, eval, ps, go} = {14'h0204, 14'h0000, 8'h01, 2'b11};
      tick(1);
      {ps, go} = 2'b00;
      tick(10);
      page(14'h0204, 14'h3FFF, 8'h00);
      chk(st === 8'h00 && irq === 1'b0, "restarted page");
      // A clear in the very cycle in which a corrupted sector ends must
      // lose; the last of 1028 bytes is taken 1029 edges after the start.
      {big, sel} = {1'b1, 3'h0};
      fork
         page(14'h0404, 14'h0000, 8'h01);
         begin
            tick(1028);
            sclr = 1'b1;
            tick(1);
            sclr = 1'b0;
         end
      join
      chk(st === 8'h01 && irq === 1'b1, "set beats clear");
      chk(|rem[13:0] === 1'b1 && (rem >> 56) === '0, "wide remainders");
      print_verdict;
   end
   // The tests need about 30k cycles; a hang is cut off well after that.
   initial begin
      #600000;
      num_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      print_verdict;
   end
endmodule

// ---- testbench/mbecc_nand_src.sv ----
// Stream source: sends len zero bytes with byte epos set to eval, with an
// optional idle cycle after each byte. Idle data toggles every cycle so a
// stale byte never looks valid.
module mbecc_nand_src (
   input wire logic clk, // Clock.
   input wire logic go, // Start a burst.
   input wire logic gap, // Idle after each byte.
   input wire logic [13:0] len, // Bytes to send.
   input wire logic [13:0] epos, // Corrupted byte index.
   input wire logic [7:0] eval, // Its value.
   output logic nand_valid, // Byte present.
   output logic [7:0] nand_data, // Byte.
   output logic done // Last byte taken.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run_ff = 1'b0;
   logic [13:0] cnt_ff = 14'h0000;
   logic [13:0] nxt_idx;
   assign nxt_idx = cnt_ff + {13'h0000, nand_valid};
   initial begin
      nand_valid = 1'b0;
      nand_data = 8'h00;
      done = 1'b0;
   end
   // A byte shown in one cycle is taken by the engine at the next edge.
   always @(posedge clk) begin
      done <= 1'b0;
      nand_valid <= 1'b0;
      nand_data <= ~nand_data;
      if (go) begin
         run_ff <= 1'b1;
         cnt_ff <= 14'h0000;
         nand_valid <= 1'b1;
         nand_data <= (epos == 14'h0000) ? eval : 8'h00;
      end else if (run_ff) begin
         if (nand_valid && nxt_idx == len) begin
            run_ff <= 1'b0;
            done <= 1'b1;
         end else begin
            cnt_ff <= nxt_idx;
            if (!nand_valid || !gap) begin
               nand_valid <= 1'b1;
               nand_data <= (nxt_idx == epos) ? eval : 8'h00;
            end
         end
      end
   end
endmodule
